/* core/dfrm_register_map.sv */
// Contract
// [RULE_01] Serial fieldbus selected opens the whole map
// [RULE_02] Control acts only with source 4, no option
// [RULE_03] Bus ramp applies only when ramp setting 1
// [RULE_04] Monitoring registers readable under any command source
// [RULE_05] Control bit 0 runs, clear stops
// [RULE_06] Control bit 1 stops on second decel ramp
// [RULE_07] Control bit 2 clears active faults
// [RULE_08] Master clears bit 2 after fault clears
// [RULE_09] Control bit 3 requests coast stop
// [RULE_10] Setpoint unsigned in 0.1 Hz steps
// [RULE_11] Ramp time 0 to 60000, both ramps
// [RULE_12] Status low byte: run, trip, hand
// [RULE_13] Status bits 3-7: inhibit to load alarm
// [RULE_14] Status high byte holds fault number when tripped
// [RULE_15] Register 7 gives output frequency
// [RULE_16] Register 8 gives output current
// [RULE_17] Register 9 gives output torque
// [RULE_18] Register 10 gives output power
// [RULE_19] Register 11 maps digital inputs bitwise
// [RULE_20] Registers 20, 21 give analog levels
// [RULE_21] Registers 30-33 give energy totals
// [RULE_22] Registers 34, 35 give running time
// [RULE_23] Function 03 reads, 06 writes single
// [RULE_24] Function 16 only for registers 1-4
// [RULE_25] Zero-based masters subtract one from numbers
// [RULE_26] Unmapped register answers illegal data address
`timescale 1ns/1ns

module dfrm_register_map
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic                   reqValid,
    input  wire dfrm_pkg::dfrm_req_t    req,
    output logic                        rspValid,
    output dfrm_pkg::dfrm_rsp_t         rsp,
    input  wire logic                   fieldbusIsModbus,
    input  wire logic [7:0]             commandSourceSelect,
    input  wire logic                   optionModulePresent,
    input  wire logic [7:0]             fieldbusRampEnable,
    input  wire dfrm_pkg::dfrm_monitor_t monitor,
    output dfrm_pkg::dfrm_cmd_t         cmd
);
    import dfrm_pkg::*;

    // ============================================================
    // Stored command registers
    // ============================================================
    logic [15:0] commandControlWord;
    logic [15:0] speedSetpoint;
    logic [15:0] rampTimeSetting;

    logic        controlActive;
    logic        rampActive;
    logic        isRead;
    logic        isWrite;
    logic        writeOk;
    logic [7:0]  next_exception;
    logic [15:0] next_rdData;
    logic        regMapped;
    logic        regWritable;

    assign controlActive = (commandSourceSelect == CMD_SRC_FIELDBUS)
                           && !optionModulePresent; // RULE_02
    assign rampActive    = (fieldbusRampEnable == RAMP_FROM_BUS); // RULE_03

    assign isRead  = (req.funcCode == FC_READ_HOLDING); // RULE_23
    assign isWrite = (req.funcCode == FC_WRITE_SINGLE)
                     || (req.funcCode == FC_WRITE_MULTIPLE); // RULE_23

    // ============================================================
    // Address decode and read mux
    // ============================================================
    always_comb
    begin
        regMapped   = 1'b1;
        regWritable = 1'b0;
        next_rdData = 16'h0000;
        case (req.regNum)
            REG_COMMAND_CONTROL_WORD:
            begin
                regWritable = 1'b1;
                next_rdData = commandControlWord;
            end
            REG_SPEED_SETPOINT:
            begin
                regWritable = 1'b1;
                next_rdData = speedSetpoint; // RULE_10
            end
            REG_SPARE_REGISTER:
            begin
                // No function behind it, so it reads as zero
                regWritable = 1'b1;
            end
            REG_RAMP_TIME_SETTING:
            begin
                regWritable = 1'b1;
                next_rdData = rampTimeSetting;
            end
            REG_FAULT_AND_STATUS:
            begin
                next_rdData[7:0]  = monitor.status; // RULE_12 RULE_13
                next_rdData[15:8] = monitor.status.tripped ? monitor.faultCode
                                                          : 8'h00; // RULE_14
            end
            REG_OUTPUT_FREQUENCY:     next_rdData = monitor.outputFrequency; // RULE_15
            REG_OUTPUT_CURRENT:       next_rdData = monitor.outputCurrent; // RULE_16
            REG_OUTPUT_TORQUE:        next_rdData = monitor.outputTorque; // RULE_17
            REG_OUTPUT_POWER:         next_rdData = monitor.outputPower; // RULE_18
            REG_DIGITAL_INPUT_MAP:    next_rdData = monitor.digitalInputMap; // RULE_19
            REG_ANALOG_ONE_LEVEL:     next_rdData = monitor.analogOneLevel; // RULE_20
            REG_ANALOG_TWO_LEVEL:     next_rdData = monitor.analogTwoLevel; // RULE_20
            REG_INTERNAL_SETPOINT:    next_rdData = monitor.internalSetpoint;
            REG_DC_BUS_VOLTAGE:       next_rdData = monitor.dcBusVoltage;
            REG_HEATSINK_TEMPERATURE: next_rdData = monitor.heatsinkTemperature;
            REG_CLEARABLE_KWH:        next_rdData = monitor.clearableKwh; // RULE_21
            REG_CLEARABLE_MWH:        next_rdData = monitor.clearableMwh; // RULE_21
            REG_LIFETIME_KWH:         next_rdData = monitor.lifetimeKwh; // RULE_21
            REG_LIFETIME_MWH:         next_rdData = monitor.lifetimeMwh; // RULE_21
            REG_RUN_TIME_HOURS:       next_rdData = monitor.runTimeHours; // RULE_22
            REG_RUN_TIME_MIN_SEC:     next_rdData = monitor.runTimeMinSec; // RULE_22
            default:
            begin
                regMapped = 1'b0; // RULE_26
            end
        endcase
    end

    // ============================================================
    // Exception decision
    // ============================================================
    // Reads never look at the command source, so monitoring stays visible
    always_comb
    begin
        next_exception = EXC_NONE;
        if (!fieldbusIsModbus)
        begin
            next_exception = EXC_ILLEGAL_FUNC; // RULE_01
        end
        else if (!isRead && !isWrite)
        begin
            next_exception = EXC_ILLEGAL_FUNC; // RULE_23
        end
        else if (!regMapped)
        begin
            next_exception = EXC_ILLEGAL_ADDR; // RULE_26
        end
        else if (isWrite && !regWritable)
        begin
            // Monitoring words are read-only; function 16 lands here for mapped registers above 4
            next_exception = EXC_ILLEGAL_ADDR; // RULE_24
        end
        else if (isWrite && (req.regNum == REG_RAMP_TIME_SETTING)
                 && (req.wrData > RAMP_TIME_MAX))
        begin
            next_exception = EXC_ILLEGAL_VALUE; // RULE_11
        end
        else
        begin
            next_exception = EXC_NONE; // RULE_04
        end
    end

    assign writeOk = reqValid && isWrite && (next_exception == EXC_NONE);

    // ============================================================
    // Register writes
    // ============================================================
    // Writes are stored whatever the source; gating is on the outputs
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            commandControlWord <= CONTROL_WORD_RESET;
            speedSetpoint      <= SETPOINT_RESET;
            rampTimeSetting    <= RAMP_TIME_RESET;
        end
        else if (writeOk)
        begin
            case (req.regNum)
                REG_COMMAND_CONTROL_WORD: commandControlWord <= req.wrData;
                REG_SPEED_SETPOINT:       speedSetpoint      <= req.wrData; // RULE_10
                REG_RAMP_TIME_SETTING:    rampTimeSetting    <= req.wrData; // RULE_11
                // Register 3 has no function: the write is taken and dropped
                default:                  rampTimeSetting    <= rampTimeSetting;
            endcase
        end
    end

    // ============================================================
    // Response
    // ============================================================
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rspValid <= 1'b0;
            rsp      <= '0;
        end
        else
        begin
            rspValid <= reqValid;
            if (reqValid)
            begin
                rsp.exception <= next_exception;
                rsp.rdData    <= (isRead && next_exception == EXC_NONE) ? next_rdData
                                                                        : 16'h0000;
            end
        end
    end

    // ============================================================
    // Drive command outputs
    // ============================================================
    // Stops override run so a stale run bit cannot fight a stop request
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd <= '0;
        end
        else
        begin
            cmd.runEnable     <= controlActive && commandControlWord[BIT_RUN]
                                 && !commandControlWord[BIT_FAST_STOP]
                                 && !commandControlWord[BIT_COAST_STOP]; // RULE_05 RULE_02
            cmd.fastStop      <= controlActive
                                 && commandControlWord[BIT_FAST_STOP]; // RULE_06
            // Level held until the master writes the bit back to zero
            cmd.faultReset    <= controlActive
                                 && commandControlWord[BIT_FAULT_RESET]; // RULE_07 RULE_08
            cmd.coastStop     <= controlActive
                                 && commandControlWord[BIT_COAST_STOP]; // RULE_09
            cmd.speedSetpoint <= controlActive ? speedSetpoint : 16'h0000; // RULE_02 RULE_10
            cmd.useBusRamp    <= rampActive; // RULE_03
            cmd.accelTime     <= rampActive ? rampTimeSetting : 16'h0000; // RULE_11
            cmd.decelTime     <= rampActive ? rampTimeSetting : 16'h0000; // RULE_11
        end
    end

    // ============================================================
    // Checks
    // ============================================================
    rsp_timing_a : assert property ( // RULE_23
        @(posedge ref_clk) disable iff (!rst_n)
        reqValid |=> rspValid)
        else $error("Response did not follow request");

    bus_select_a : assert property ( // RULE_01
        @(posedge ref_clk) disable iff (!rst_n)
        (reqValid && !fieldbusIsModbus) |=> (rsp.exception == EXC_ILLEGAL_FUNC))
        else $error("Access allowed without serial fieldbus");

    unmapped_addr_a : assert property ( // RULE_26
        @(posedge ref_clk) disable iff (!rst_n)
        (reqValid && fieldbusIsModbus && isRead && req.regNum == 16'h0005)
        |=> (rsp.exception == EXC_ILLEGAL_ADDR))
        else $error("Unmapped register not refused");

    multi_write_a : assert property ( // RULE_24
        @(posedge ref_clk) disable iff (!rst_n)
        (reqValid && fieldbusIsModbus && req.funcCode == FC_WRITE_MULTIPLE
         && req.regNum > REG_RAMP_TIME_SETTING)
        |=> (rsp.exception != EXC_NONE))
        else $error("Multiple write accepted above register 4");

    ramp_range_a : assert property ( // RULE_11
        @(posedge ref_clk) disable iff (!rst_n)
        (writeOk && req.regNum == REG_RAMP_TIME_SETTING) ##1 rampActive
        |=> (cmd.accelTime == $past(req.wrData, 2)) && (cmd.decelTime == cmd.accelTime))
        else $error("Ramp time not applied to both ramps");

    ramp_gate_a : assert property ( // RULE_03
        @(posedge ref_clk) disable iff (!rst_n)
        !rampActive |=> (!cmd.useBusRamp && cmd.accelTime == 16'h0000))
        else $error("Bus ramp applied while disabled");

    control_gate_a : assert property ( // RULE_02
        @(posedge ref_clk) disable iff (!rst_n)
        !controlActive |=> (!cmd.runEnable && !cmd.faultReset
                            && cmd.speedSetpoint == 16'h0000))
        else $error("Control acted without fieldbus source");

    run_bit_a : assert property ( // RULE_05
        @(posedge ref_clk) disable iff (!rst_n)
        (writeOk && req.regNum == REG_COMMAND_CONTROL_WORD && req.wrData[3:0] == 4'h1)
        ##1 controlActive |=> cmd.runEnable)
        else $error("Run bit did not enable the drive");

    fault_reset_a : assert property ( // RULE_07
        @(posedge ref_clk) disable iff (!rst_n)
        (controlActive && commandControlWord[BIT_FAULT_RESET]) |=> cmd.faultReset)
        else $error("Fault reset not issued");

    status_read_a : assert property ( // RULE_14
        @(posedge ref_clk) disable iff (!rst_n)
        (reqValid && fieldbusIsModbus && isRead && req.regNum == REG_FAULT_AND_STATUS)
        |=> (rsp.rdData[7:0] == $past(monitor.status))
            && (rsp.rdData[15:8] == ($past(monitor.status.tripped) ? $past(monitor.faultCode)
                                                                   : 8'h00)))
        else $error("Status word read wrong");

    monitor_read_a : assert property ( // RULE_15
        @(posedge ref_clk) disable iff (!rst_n)
        (reqValid && fieldbusIsModbus && isRead && req.regNum == REG_OUTPUT_FREQUENCY)
        |=> (rsp.exception == EXC_NONE && rsp.rdData == $past(monitor.outputFrequency)))
        else $error("Output frequency read wrong");

    stop_override_a : assert property ( // RULE_09
        @(posedge ref_clk) disable iff (!rst_n)
        (controlActive && commandControlWord[BIT_COAST_STOP])
        |=> (cmd.coastStop && !cmd.runEnable))
        else $error("Coast stop did not override run");

    speed_apply_a : assert property ( // RULE_10
        @(posedge ref_clk) disable iff (!rst_n)
        controlActive |=> (cmd.speedSetpoint == $past(speedSetpoint)))
        else $error("Setpoint not passed to the drive");

endmodule : dfrm_register_map

/* core/dfrm_pkg.sv */
package dfrm_pkg;

    // ============================================================
    // Register numbers, 1-based as the master lists them
    // ============================================================
    localparam logic [15:0] REG_COMMAND_CONTROL_WORD = 16'h0001;
    localparam logic [15:0] REG_SPEED_SETPOINT       = 16'h0002;
    localparam logic [15:0] REG_SPARE_REGISTER       = 16'h0003;
    localparam logic [15:0] REG_RAMP_TIME_SETTING    = 16'h0004;
    localparam logic [15:0] REG_FAULT_AND_STATUS     = 16'h0006;
    localparam logic [15:0] REG_OUTPUT_FREQUENCY     = 16'h0007;
    localparam logic [15:0] REG_OUTPUT_CURRENT       = 16'h0008;
    localparam logic [15:0] REG_OUTPUT_TORQUE        = 16'h0009;
    localparam logic [15:0] REG_OUTPUT_POWER         = 16'h000A;
    localparam logic [15:0] REG_DIGITAL_INPUT_MAP    = 16'h000B;
    localparam logic [15:0] REG_ANALOG_ONE_LEVEL     = 16'h0014;
    localparam logic [15:0] REG_ANALOG_TWO_LEVEL     = 16'h0015;
    localparam logic [15:0] REG_INTERNAL_SETPOINT    = 16'h0016;
    localparam logic [15:0] REG_DC_BUS_VOLTAGE       = 16'h0017;
    localparam logic [15:0] REG_HEATSINK_TEMPERATURE = 16'h0018;
    localparam logic [15:0] REG_CLEARABLE_KWH        = 16'h001E;
    localparam logic [15:0] REG_CLEARABLE_MWH        = 16'h001F;
    localparam logic [15:0] REG_LIFETIME_KWH         = 16'h0020;
    localparam logic [15:0] REG_LIFETIME_MWH         = 16'h0021;
    localparam logic [15:0] REG_RUN_TIME_HOURS       = 16'h0022;
    localparam logic [15:0] REG_RUN_TIME_MIN_SEC     = 16'h0023;

    // ============================================================
    // Function codes and exception codes
    // ============================================================
    localparam logic [7:0] FC_READ_HOLDING    = 8'h03;
    localparam logic [7:0] FC_WRITE_SINGLE    = 8'h06;
    localparam logic [7:0] FC_WRITE_MULTIPLE  = 8'h10;
    localparam logic [7:0] EXC_NONE           = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_FUNC   = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDR   = 8'h02;
    localparam logic [7:0] EXC_ILLEGAL_VALUE  = 8'h03;

    // ============================================================
    // Fields, settings and reset values
    // ============================================================
    localparam int          BIT_RUN            = 0;
    localparam int          BIT_FAST_STOP      = 1;
    localparam int          BIT_FAULT_RESET    = 2;
    localparam int          BIT_COAST_STOP     = 3;
    localparam logic [7:0]  CMD_SRC_FIELDBUS   = 8'h04;
    localparam logic [7:0]  RAMP_FROM_BUS      = 8'h01;
    localparam logic [15:0] RAMP_TIME_MAX      = 16'hEA60;
    localparam logic [15:0] CONTROL_WORD_RESET = 16'h0000;
    localparam logic [15:0] SETPOINT_RESET     = 16'h0000;
    localparam logic [15:0] RAMP_TIME_RESET    = 16'h0000;
    localparam logic [15:0] SPARE_RESET        = 16'h0000;

    // ============================================================
    // Carriers
    // ============================================================
    typedef struct packed {
        logic [7:0]  funcCode;
        logic [15:0] regNum;
        logic [15:0] wrData;
    } dfrm_req_t;

    typedef struct packed {
        logic [7:0]  exception;
        logic [15:0] rdData;
    } dfrm_rsp_t;

    typedef struct packed {
        logic loadAlarm;
        logic driveReady;
        logic standby;
        logic serviceDue;
        logic inhibit;
        logic handMode;
        logic tripped;
        logic running;
    } dfrm_status_t;

    typedef struct packed {
        dfrm_status_t status;
        logic [7:0]   faultCode;
        logic [15:0]  outputFrequency;
        logic [15:0]  outputCurrent;
        logic [15:0]  outputTorque;
        logic [15:0]  outputPower;
        logic [15:0]  digitalInputMap;
        logic [15:0]  analogOneLevel;
        logic [15:0]  analogTwoLevel;
        logic [15:0]  internalSetpoint;
        logic [15:0]  dcBusVoltage;
        logic [15:0]  heatsinkTemperature;
        logic [15:0]  clearableKwh;
        logic [15:0]  clearableMwh;
        logic [15:0]  lifetimeKwh;
        logic [15:0]  lifetimeMwh;
        logic [15:0]  runTimeHours;
        logic [15:0]  runTimeMinSec;
    } dfrm_monitor_t;

    typedef struct packed {
        logic        runEnable;
        logic        fastStop;
        logic        faultReset;
        logic        coastStop;
        logic [15:0] speedSetpoint;
        logic        useBusRamp;
        logic [15:0] accelTime;
        logic [15:0] decelTime;
    } dfrm_cmd_t;

endpackage : dfrm_pkg

/* test/dfrm_master_model.sv */
`timescale 1ns/1ns

module dfrm_master_model
(
    input  wire logic                ref_clk,
    output logic                     reqValid,
    output dfrm_pkg::dfrm_req_t      req,
    input  wire logic                rspValid,
    input  wire dfrm_pkg::dfrm_rsp_t rsp
);
    import dfrm_pkg::*;

    // ============================================================
    // Idle state
    // ============================================================
    initial
    begin
        reqValid = 1'b0;
        req      = '0;
    end

    // ============================================================
    // One single-register transaction
    // ============================================================
    // Numbers go out as listed: the map counts from one
    task automatic access(
        input  logic [7:0]  fc,
        input  logic [15:0] num,
        input  logic [15:0] data,
        output logic        seen,
        output logic [7:0]  exc,
        output logic [15:0] rd
    );
        @(negedge ref_clk);
        reqValid = 1'b1;
        req      = '{funcCode: fc, regNum: num, wrData: data};
        @(posedge ref_clk);
        @(negedge ref_clk);
        reqValid = 1'b0;
        // Released lines never keep the old value
        req      = ~req;
        seen     = rspValid;
        exc      = rsp.exception;
        rd       = rsp.rdData;
    endtask : access

endmodule : dfrm_master_model

/* test/tb.sv */
`timescale 1ns/1ns

module tb;
    import dfrm_pkg::*;

    // ============================================================
    // Signals
    // ============================================================
    logic          ref_clk;
    logic          rst_n;
    logic          reqValid;
    dfrm_req_t     req;
    logic          rspValid;
    dfrm_rsp_t     rsp;
    logic          fieldbusIsModbus;
    logic [7:0]    commandSourceSelect;
    logic          optionModulePresent;
    logic [7:0]    fieldbusRampEnable;
    dfrm_monitor_t monitor;
    dfrm_cmd_t     cmd;
    int            bad_count;
    int            checks_done;
    int            roRegs [16] = '{7, 8, 9, 10, 11, 20, 21, 22, 23, 24, 30, 31, 32, 33, 34, 35};
    int            badRegs [7] = '{0, 5, 12, 19, 25, 29, 36};

    dfrm_register_map dfrm_register_map_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .reqValid(reqValid), .req(req),
        .rspValid(rspValid), .rsp(rsp), .fieldbusIsModbus(fieldbusIsModbus),
        .commandSourceSelect(commandSourceSelect), .optionModulePresent(optionModulePresent),
        .fieldbusRampEnable(fieldbusRampEnable), .monitor(monitor), .cmd(cmd));

    dfrm_master_model dfrm_master_model_i (
        .ref_clk(ref_clk), .reqValid(reqValid), .req(req), .rspValid(rspValid), .rsp(rsp));

    // ============================================================
    // Clock, verdict and compare helpers
    // ============================================================
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic test_done;
        $display("counts: %0d mismatches, %0d checks", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkWord

    // Every response must arrive one cycle after its request
    task automatic xfer(input logic [7:0] fc, input logic [15:0] num, input logic [15:0] data,
                        input logic [7:0] expExc, input logic [15:0] expRd);
        logic        seen;
        logic [7:0]  exc;
        logic [15:0] rd;
        dfrm_master_model_i.access(fc, num, data, seen, exc, rd);
        chkWord({15'h0000, seen}, 16'h0001);
        chkWord({8'h00, exc}, {8'h00, expExc});
        chkWord(rd, expRd);
    endtask : xfer

    task automatic settle;
        @(negedge ref_clk);
    endtask : settle

    // ============================================================
    // Scenarios
    // ============================================================
    task automatic test_monitor;
        commandSourceSelect = 8'h01;
        for (int k = 0; k < 16; k++)
            monitor[255 - 16 * k -: 16] = 16'h1100 + 16'(roRegs[k]);
        for (int k = 0; k < 16; k++)
            xfer(FC_READ_HOLDING, 16'(roRegs[k]), 16'h0000, EXC_NONE, 16'h1100 + 16'(roRegs[k]));
        monitor.faultCode       = 8'h3C;
        monitor.status          = '0;
        monitor.status.handMode  = 1'b1;
        monitor.status.loadAlarm = 1'b1;
        xfer(FC_READ_HOLDING, REG_FAULT_AND_STATUS, 16'h0000, EXC_NONE, 16'h0084);
        monitor.status          = '0;
        monitor.status.running  = 1'b1;
        monitor.status.inhibit  = 1'b1;
        monitor.status.standby  = 1'b1;
        xfer(FC_READ_HOLDING, REG_FAULT_AND_STATUS, 16'h0000, EXC_NONE, 16'h0029);
        monitor.status            = '0;
        monitor.status.tripped    = 1'b1;
        monitor.status.serviceDue = 1'b1;
        monitor.status.driveReady = 1'b1;
        xfer(FC_READ_HOLDING, REG_FAULT_AND_STATUS, 16'h0000, EXC_NONE, 16'h3C52);
        commandSourceSelect = CMD_SRC_FIELDBUS;
    endtask : test_monitor

    task automatic test_access;
        for (int k = 0; k < 7; k++)
            xfer(FC_READ_HOLDING, 16'(badRegs[k]), 16'h0000, EXC_ILLEGAL_ADDR, 16'h0000);
        xfer(FC_WRITE_SINGLE, REG_OUTPUT_FREQUENCY, 16'h0005, EXC_ILLEGAL_ADDR, 16'h0000);
        xfer(8'h04, REG_OUTPUT_FREQUENCY, 16'h0000, EXC_ILLEGAL_FUNC, 16'h0000);
        xfer(FC_WRITE_MULTIPLE, REG_FAULT_AND_STATUS, 16'h0001, EXC_ILLEGAL_ADDR, 16'h0000);
        xfer(FC_WRITE_MULTIPLE, REG_SPEED_SETPOINT, 16'h1234, EXC_NONE, 16'h0000);
        xfer(FC_READ_HOLDING, REG_SPEED_SETPOINT, 16'h0000, EXC_NONE, 16'h1234);
        xfer(FC_WRITE_SINGLE, REG_SPARE_REGISTER, 16'hBEEF, EXC_NONE, 16'h0000);
        xfer(FC_READ_HOLDING, REG_SPARE_REGISTER, 16'h0000, EXC_NONE, 16'h0000);
        fieldbusIsModbus = 1'b0;
        xfer(FC_READ_HOLDING, REG_OUTPUT_FREQUENCY, 16'h0000, EXC_ILLEGAL_FUNC, 16'h0000);
        fieldbusIsModbus = 1'b1;
    endtask : test_access

    task automatic ctl(input logic [15:0] word, input logic [3:0] expBits);
        xfer(FC_WRITE_SINGLE, REG_COMMAND_CONTROL_WORD, word, EXC_NONE, 16'h0000);
        settle;
        chkWord({12'h000, cmd.coastStop, cmd.faultReset, cmd.fastStop, cmd.runEnable},
                {12'h000, expBits});
    endtask : ctl

    task automatic test_control;
        ctl(16'h0001, 4'h1);
        ctl(16'h0000, 4'h0);
        ctl(16'h0003, 4'h2);
        ctl(16'h0004, 4'h4);
        ctl(16'h0000, 4'h0);
        ctl(16'h0009, 4'h8);
        xfer(FC_WRITE_SINGLE, REG_SPEED_SETPOINT, 16'd500, EXC_NONE, 16'h0000);
        ctl(16'h0001, 4'h1);
        chkWord(cmd.speedSetpoint, 16'd500);
        optionModulePresent = 1'b1;
        settle;
        chkWord({cmd.speedSetpoint[15:1], cmd.runEnable}, 16'h0000);
        optionModulePresent = 1'b0;
        commandSourceSelect = 8'h03;
        settle;
        chkWord({cmd.speedSetpoint[15:1], cmd.runEnable}, 16'h0000);
        commandSourceSelect = CMD_SRC_FIELDBUS;
        settle;
        chkWord({15'h0000, cmd.runEnable}, 16'h0001);
    endtask : test_control

    task automatic test_ramp;
        xfer(FC_WRITE_SINGLE, REG_RAMP_TIME_SETTING, 16'hEA60, EXC_NONE, 16'h0000);
        settle;
        chkWord(cmd.accelTime, 16'hEA60);
        chkWord(cmd.decelTime, 16'hEA60);
        chkWord({15'h0000, cmd.useBusRamp}, 16'h0001);
        xfer(FC_WRITE_SINGLE, REG_RAMP_TIME_SETTING, 16'hEA61, EXC_ILLEGAL_VALUE, 16'h0000);
        xfer(FC_READ_HOLDING, REG_RAMP_TIME_SETTING, 16'h0000, EXC_NONE, 16'hEA60);
        fieldbusRampEnable = 8'h00;
        settle;
        chkWord({cmd.useBusRamp, cmd.accelTime[14:0]}, 16'h0000);
        chkWord(cmd.decelTime, 16'h0000);
    endtask : test_ramp

    // ============================================================
    // Main sequence and watchdog
    // ============================================================
    initial
    begin
        bad_count           = 0;
        checks_done         = 0;
        rst_n               = 1'b0;
        fieldbusIsModbus    = 1'b1;
        commandSourceSelect = CMD_SRC_FIELDBUS;
        optionModulePresent = 1'b0;
        fieldbusRampEnable  = RAMP_FROM_BUS;
        monitor             = '0;
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        chkWord({15'h0000, rspValid}, 16'h0000);
        xfer(FC_READ_HOLDING, REG_COMMAND_CONTROL_WORD, 16'h0000, EXC_NONE,
             CONTROL_WORD_RESET);
        test_monitor;
        test_access;
        test_control;
        test_ramp;
        test_done;
    end

    // Whole run needs about a microsecond; far more means a hang
    initial
    begin
        #100000;
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        test_done;
    end

endmodule : tb
